// ==== inc/scb_pkg.sv ====
/*
 * Constants of the synthesizer configuration register bank:
 * byte offsets, field positions, masks, codes and reset values.
 * Assumes an 8-bit register port addressed by byte offset.
 */
package scb_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] ADDR_DEV_CTRL = 8'h02;
   localparam logic [7:0] ADDR_CFG1 = 8'h03;
   localparam logic [7:0] ADDR_CFG2 = 8'h04;
   localparam logic [7:0] ADDR_GLOBAL = 8'h05;
   localparam logic [7:0] ADDR_RATIO_BASE = 8'h06;
   localparam logic [7:0] ADDR_RATIO_LAST = 8'h15;
   localparam logic [7:0] ADDR_FUNC1 = 8'h16;
   localparam logic [7:0] ADDR_FUNC2 = 8'h17;
   // ****************************************
   // field positions
   // ****************************************
   localparam int UNLOCK_BIT = 7;
   localparam int AUX_DIS_BIT = 1;
   localparam int CLK_DIS_BIT = 0;
   localparam int STATIC_RATIO_SELECT_LSB = 3;
   localparam int AUX_SRC_LSB = 1;
   localparam int EN_FIRST_BIT = 0;
   localparam int HYB_SEL_LSB = 1;
   localparam int FRAC_SRC_BIT = 0;
   localparam int FREEZE_BIT = 3;
   localparam int EN_SECOND_BIT = 0;
   localparam int SKIP_BIT = 7;
   localparam int LOCK_CFG_BIT = 6;
   localparam int DIV_LSB = 3;
   localparam int OUT_UNL_BIT = 4;
   // ****************************************
   // writable bit masks, reserved bits are zero
   // ****************************************
   localparam logic [7:0] MASK_DEV_CTRL = 8'h03;
   localparam logic [7:0] MASK_CFG1 = 8'h1F;
   localparam logic [7:0] MASK_CFG2 = 8'h07;
   localparam logic [7:0] MASK_GLOBAL = 8'h09;
   localparam logic [7:0] MASK_FUNC1 = 8'hD8;
   localparam logic [7:0] MASK_FUNC2 = 8'h10;
   // ****************************************
   // reset values and codes
   // ****************************************
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [31:0] RESET_RATIO = 32'h0000_0000;
   localparam int NUM_RATIOS = 4;
   localparam logic [1:0] AUX_SRC_REF = 2'h0;
   localparam logic [1:0] AUX_SRC_FREQ = 2'h1;
   localparam logic [1:0] AUX_SRC_SYNTH = 2'h2;
   localparam logic [1:0] AUX_SRC_LOCK = 2'h3;
   localparam logic [1:0] DIV_BY4 = 2'h0;
   localparam logic [1:0] DIV_BY2 = 2'h1;
   localparam logic [1:0] DIV_BY1 = 2'h2;
endpackage

// ==== inc/scb_cfg_if.sv ====
/*
 * Active configuration and synchronised pin levels passed from the
 * register bank to the pin output stage. Same clock on both sides.
 */
`timescale 1ns/100ps
`default_nettype none
interface scb_cfg_if;
   logic [1:0] aux_sel;
   logic [1:0] div_sel;
   logic lock_cfg;
   logic aux_dis;
   logic clk_dis;
   logic out_on_unl;
   logic run;
   logic ref_s;
   logic ref_rise;
   logic freq_s;
   logic synth_s;
   logic unlock_s;
   modport ctl(output aux_sel, div_sel, lock_cfg, aux_dis, clk_dis, out_on_unl,
      run, ref_s, ref_rise, freq_s, synth_s, unlock_s);
   modport pins(input aux_sel, div_sel, lock_cfg, aux_dis, clk_dis, out_on_unl,
      run, ref_s, ref_rise, freq_s, synth_s, unlock_s);
endinterface
`default_nettype wire

// ==== hw/scb_sync.sv ====
/*
 * Two-flop synchroniser for a vector of pin levels, with a rise pulse
 * taken from the second stage. Assumes inputs are asynchronous to mclk.
 */
`timescale 1ns/100ps
`default_nettype none
module scb_sync #(
   parameter int W = 4
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] rise
);
   logic [W-1:0] meta;
   logic [W-1:0] last;
   if (W < 1) begin : g_chk
      $error("scb_sync: W must be at least 1");
   end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         meta <= '0;
         q <= '0;
         last <= '0;
      end else if (ce) begin
         meta <= d;
         q <= meta;
         last <= q;
      end
   end
   assign rise = q & ~last & {W{ce}};
endmodule
`default_nettype wire

// ==== hw/scb_pin_out.sv ====
/*
 * Pin output stage: reference divider, clock output gating on unlock
 * and auxiliary output source mux. Assumes synchronised inputs.
 */
`timescale 1ns/100ps
`default_nettype none
module scb_pin_out
   import scb_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   scb_cfg_if.pins cfg,
   output logic aux_out,
   output logic aux_out_oe,
   output logic clk_out,
   output logic clk_out_oe,
   output logic ref_div_clk
);
   logic half;
   // ****************************************
   // reference divider
   // ****************************************
   wire div_toggle = cfg.ref_rise &
      ((cfg.div_sel == DIV_BY2) | ((cfg.div_sel == DIV_BY4) & half)); // [R12]
   wire next_half = (cfg.ref_rise & (cfg.div_sel == DIV_BY4)) ? ~half : half;
   // reserved code holds the divided clock
   wire next_ref_div_clk = (cfg.div_sel == DIV_BY1) ? cfg.ref_s :
      (ref_div_clk ^ div_toggle); // [R12]
   // ****************************************
   // clock output and auxiliary mux
   // ****************************************
   wire gate_low = cfg.unlock_s & ~cfg.out_on_unl; // [R13]
   wire next_clk_out = cfg.run & cfg.synth_s & ~gate_low; // [R13] [R3]
   wire is_lock = (cfg.aux_sel == AUX_SRC_LOCK); // [R11]
   wire lock_val = cfg.lock_cfg ? 1'b0 : cfg.unlock_s; // [R10]
   wire next_aux_out = (cfg.aux_sel == AUX_SRC_REF) ? cfg.ref_s :
      (cfg.aux_sel == AUX_SRC_FREQ) ? cfg.freq_s :
      (cfg.aux_sel == AUX_SRC_SYNTH) ? next_clk_out : lock_val; // [R2]
   // open drain releases while locked
   wire next_aux_oe = ~cfg.aux_dis &
      (~is_lock | ~cfg.lock_cfg | cfg.unlock_s); // [R10] [R11]
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         half <= 1'b0;
         ref_div_clk <= 1'b0;
         clk_out <= 1'b0;
         clk_out_oe <= 1'b0;
         aux_out <= 1'b0;
         aux_out_oe <= 1'b0;
      end else if (ce) begin
         half <= next_half;
         ref_div_clk <= next_ref_div_clk;
         clk_out <= next_clk_out;
         clk_out_oe <= ~cfg.clk_dis;
         aux_out <= next_aux_out;
         aux_out_oe <= next_aux_oe;
      end
   end
endmodule
`default_nettype wire

// ==== hw/scb_top.sv ====
/*
 * Configuration register bank of a fractional-N clock synthesizer.
 * Holds ratio storage, ratio selection, freeze staging, enables and
 * the pin configuration. Assumes the serial control port logic on mclk
 * presents byte writes and reads on a parallel strobe port, and that
 * the clock and lock pins are asynchronous to mclk.
 */

`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1 - The static ratio select picks stored ratio 0..3 for the static synthesizer mode.
// R2 - The aux source select routes reference, frequency input, synth clock or lock status.
// R3 - Normal operation starts only when both enable bits are one, set in any order.
// R4 - The hybrid ratio select picks stored ratio 0..3 for the hybrid PLL mode.
// R5 - The fractional source bit feeds the static ratio when 0 and the PLL ratio when 1.
// R6 - While frozen, control and configuration writes are held until freeze clears.
// R7 - Each ratio is four byte registers, lowest address holding the top byte.
// R8 - The skip-mode bit lets the PLL hold lock across missing reference pulses.
// R9 - The frequency reference source must stay below 80 kHz and resume within 20 ms.
// R10 - Lock indicator is push-pull high on unlock, or open drain low on unlock.
// R11 - The lock drive bit matters only when the aux source is the lock indicator.
// R12 - The reference divider divides by 4, 2 or 1, and code 11 is reserved.
// R13 - Unlocked clock outputs go low unless output-on-unlock is set.
// R14 - The read-only unlock bit reads 1 while the PLL is unlocked.
// R15 - The host keeps reserved bits at their default value on every write.
// R16 - Frozen writes are staged and all transfer together when freeze clears.
module scb_top
   import scb_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic timing_reference_clock,
   input wire logic freq_ref_clock,
   input wire logic synth_clock,
   input wire logic pll_unlock,
   input wire logic [31:0] dpll_ratio,
   output logic [31:0] static_ratio,
   output logic [31:0] hybrid_ratio,
   output logic [31:0] frac_ratio,
   output logic fractional_source_select,
   output logic skip_mode_enable,
   output logic normal_operation,
   output logic aux_out,
   output logic aux_out_oe,
   output logic clk_out,
   output logic clk_out_oe,
   output logic ref_div_clk
);
   // ****************************************
   // storage
   // ****************************************
   // staged copies
   logic [7:0] ctrl_shadow;
   logic [7:0] cfg1_shadow;
   logic [7:0] cfg2_shadow;

   // live copies
   logic [7:0] ctrl_active;
   logic [7:0] cfg1_active;
   logic [7:0] cfg2_active;

   // never frozen
   logic [7:0] global_cfg;
   logic [7:0] func1_cfg;
   logic [7:0] func2_cfg;

   logic [31:0] ratio_mem [NUM_RATIOS];

   logic [3:0] pin_q;
   logic [3:0] pin_rise;

   scb_cfg_if cfg_bus ();

   // ****************************************
   // pin synchronisers
   // ****************************************
   scb_sync #(
      .W(4)
   ) u_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ce(ce),
      .d({pll_unlock, synth_clock, freq_ref_clock, timing_reference_clock}),
      .q(pin_q),
      .rise(pin_rise)
   );

   // synced levels
   wire ref_s = pin_q[0];
   wire freq_s = pin_q[1];
   wire synth_s = pin_q[2];
   wire unlock_s = pin_q[3];

   // ****************************************
   // write decode
   // ****************************************
   wire wr_ctrl = reg_wr & (reg_addr == ADDR_DEV_CTRL);
   wire wr_cfg1 = reg_wr & (reg_addr == ADDR_CFG1);
   wire wr_cfg2 = reg_wr & (reg_addr == ADDR_CFG2);
   wire wr_global = reg_wr & (reg_addr == ADDR_GLOBAL);
   wire wr_func1 = reg_wr & (reg_addr == ADDR_FUNC1);
   wire wr_func2 = reg_wr & (reg_addr == ADDR_FUNC2);

   // ratio window
   wire in_ratio = (reg_addr >= ADDR_RATIO_BASE) & (reg_addr <= ADDR_RATIO_LAST);
   wire wr_ratio = reg_wr & in_ratio;
   wire [7:0] ratio_off = reg_addr - ADDR_RATIO_BASE;
   wire [1:0] ratio_idx = ratio_off[3:2];
   // lowest address of a group is the top byte
   wire [4:0] ratio_lsb = {~ratio_off[1:0], 3'h0}; // [R7]

   // reserved bits are not stored and read back as zero
   wire [7:0] wmask_ctrl = reg_wdata & MASK_DEV_CTRL; // [R15]
   wire [7:0] wmask_cfg1 = reg_wdata & MASK_CFG1; // [R15]
   wire [7:0] wmask_cfg2 = reg_wdata & MASK_CFG2; // [R15]

   // ****************************************
   // freeze staging
   // ****************************************
   wire [7:0] next_ctrl_shadow = wr_ctrl ? wmask_ctrl : ctrl_shadow;
   wire [7:0] next_cfg1_shadow = wr_cfg1 ? wmask_cfg1 : cfg1_shadow;
   wire [7:0] next_cfg2_shadow = wr_cfg2 ? wmask_cfg2 : cfg2_shadow;

   wire [7:0] next_global_cfg = wr_global ? (reg_wdata & MASK_GLOBAL) : global_cfg;
   wire next_freeze = next_global_cfg[FREEZE_BIT];
   // all staged bytes move together once freeze is low
   wire load_active = ~next_freeze; // [R6] [R16]

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_shadow <= RESET_BYTE;
         cfg1_shadow <= RESET_BYTE;
         cfg2_shadow <= RESET_BYTE;
         global_cfg <= RESET_BYTE;
      end else if (ce) begin
         ctrl_shadow <= next_ctrl_shadow; // [R16]
         cfg1_shadow <= next_cfg1_shadow; // [R16]
         cfg2_shadow <= next_cfg2_shadow; // [R16]
         global_cfg <= next_global_cfg;
      end
   end

   // held while frozen
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_active <= RESET_BYTE;
         cfg1_active <= RESET_BYTE;
         cfg2_active <= RESET_BYTE;
      end else if (ce && load_active) begin
         ctrl_active <= next_ctrl_shadow; // [R6] [R16]
         cfg1_active <= next_cfg1_shadow; // [R6] [R16]
         cfg2_active <= next_cfg2_shadow; // [R6] [R16]
      end
   end

   // ****************************************
   // function configuration, never frozen
   // ****************************************
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         func1_cfg <= RESET_BYTE;
         func2_cfg <= RESET_BYTE;
      end else if (ce) begin
         if (wr_func1) begin
            func1_cfg <= reg_wdata & MASK_FUNC1; // [R15]
         end

         if (wr_func2) begin
            func2_cfg <= reg_wdata & MASK_FUNC2; // [R15]
         end
      end
   end

   // ****************************************
   // ratio storage
   // ****************************************
   // one byte lane per write
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_RATIOS; i++) begin
            ratio_mem[i] <= RESET_RATIO;
         end
      end else if (ce && wr_ratio) begin
         ratio_mem[ratio_idx][ratio_lsb +: 8] <= reg_wdata; // [R7]
      end
   end

   // ****************************************
   // field extraction
   // ****************************************
   wire aux_dis = ctrl_active[AUX_DIS_BIT];
   wire clk_dis = ctrl_active[CLK_DIS_BIT];

   wire [1:0] static_sel = cfg1_active[STATIC_RATIO_SELECT_LSB +: 2];
   wire [1:0] aux_source_select = cfg1_active[AUX_SRC_LSB +: 2];
   wire config_enable_first = cfg1_active[EN_FIRST_BIT];

   wire [1:0] hybrid_sel = cfg2_active[HYB_SEL_LSB +: 2];
   wire frac_src = cfg2_active[FRAC_SRC_BIT];

   wire config_enable_second = global_cfg[EN_SECOND_BIT];

   wire skip_bit = func1_cfg[SKIP_BIT];
   wire lock_drive_config = func1_cfg[LOCK_CFG_BIT];
   wire [1:0] reference_divider_select = func1_cfg[DIV_LSB +: 2];

   wire output_on_unlock = func2_cfg[OUT_UNL_BIT];

   // ****************************************
   // ratio selection
   // ****************************************
   wire [31:0] effective_ratio = ratio_mem[static_sel]; // [R1]

   wire [31:0] next_hybrid_ratio = ratio_mem[hybrid_sel]; // [R4]

   // auto switching is not present, so the bit alone decides
   wire [31:0] next_frac_ratio = frac_src ? dpll_ratio : effective_ratio; // [R5]

   // either enable may come first
   wire next_run = config_enable_first & config_enable_second; // [R3]

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         static_ratio <= RESET_RATIO;
         hybrid_ratio <= RESET_RATIO;
         frac_ratio <= RESET_RATIO;
         fractional_source_select <= 1'b0;
         skip_mode_enable <= 1'b0;
         normal_operation <= 1'b0;
      end else if (ce) begin
         static_ratio <= effective_ratio; // [R1]
         hybrid_ratio <= next_hybrid_ratio; // [R4]
         frac_ratio <= next_frac_ratio; // [R5]
         fractional_source_select <= frac_src; // [R5]
         skip_mode_enable <= skip_bit; // [R8]
         normal_operation <= next_run; // [R3]
      end
   end

   // ****************************************
   // read path
   // ****************************************
   wire [7:0] ctrl_read = {unlock_s, ctrl_shadow[6:0]}; // [R14]

   wire [7:0] ratio_read = ratio_mem[ratio_idx][ratio_lsb +: 8]; // [R7]

   // unmapped reads give zero
   wire [7:0] read_mux =
      (reg_addr == ADDR_DEV_CTRL) ? ctrl_read :
      (reg_addr == ADDR_CFG1) ? cfg1_shadow :
      (reg_addr == ADDR_CFG2) ? cfg2_shadow :
      (reg_addr == ADDR_GLOBAL) ? global_cfg :
      (reg_addr == ADDR_FUNC1) ? func1_cfg :
      (reg_addr == ADDR_FUNC2) ? func2_cfg :
      in_ratio ? ratio_read : RESET_BYTE;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= RESET_BYTE;
      end else if (ce && reg_rd) begin
         reg_rdata <= read_mux;
      end
   end

   // ****************************************
   // pin stage hookup
   // ****************************************
   assign cfg_bus.aux_sel = aux_source_select; // [R2]
   assign cfg_bus.div_sel = reference_divider_select; // [R12]
   assign cfg_bus.lock_cfg = lock_drive_config; // [R10]
   assign cfg_bus.aux_dis = aux_dis;
   assign cfg_bus.clk_dis = clk_dis;

   assign cfg_bus.out_on_unl = output_on_unlock; // [R13]
   assign cfg_bus.run = normal_operation; // [R3]

   assign cfg_bus.ref_s = ref_s;
   assign cfg_bus.ref_rise = pin_rise[0];

   assign cfg_bus.freq_s = freq_s;
   assign cfg_bus.synth_s = synth_s;
   assign cfg_bus.unlock_s = unlock_s; // [R14]

   scb_pin_out u_pins (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ce(ce),
      .cfg(cfg_bus),
      .aux_out(aux_out),
      .aux_out_oe(aux_out_oe),
      .clk_out(clk_out),
      .clk_out_oe(clk_out_oe),
      .ref_div_clk(ref_div_clk)
   );
endmodule
`default_nettype wire

// ==== dv/scb_assertions.sv ====
/* Concurrent checks on the register bank top ports.
   Assumes one mclk domain and a bind onto scb_top. */
`timescale 1ns/100ps
`default_nettype none
module scb_assertions
   import scb_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic pll_unlock,
   input wire logic [31:0] dpll_ratio,
   input wire logic [31:0] static_ratio,
   input wire logic [31:0] frac_ratio,
   input wire logic fractional_source_select,
   input wire logic skip_mode_enable,
   input wire logic normal_operation,
   input wire logic clk_out
);
   // ****************************************
   // unlock pin quiet time, then properties
   // ****************************************
   logic [2:0] unl_cnt;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         unl_cnt <= 3'h0;
      end else if ($changed(pll_unlock) || !ce) begin
         unl_cnt <= 3'h0;
      end else if (unl_cnt != 3'h7) begin
         unl_cnt <= unl_cnt + 3'h1;
      end
   end
   default clocking @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   property p_frac_pick;
      ce && $past(ce) && $stable(fractional_source_select) && $stable(dpll_ratio)
         && $stable(static_ratio)
         |-> frac_ratio == (fractional_source_select ? dpll_ratio : static_ratio);
   endproperty
   a_frac_pick: assert property (p_frac_pick)
      else $error("frac ratio not from selected source");
   property p_idle_clk;
      !normal_operation && !$past(normal_operation) && !$past(normal_operation, 2)
         |-> !clk_out;
   endproperty
   a_idle_clk: assert property (p_idle_clk)
      else $error("clock output active before normal operation");
   property p_unlock_read;
      ce && reg_rd && reg_addr == ADDR_DEV_CTRL && unl_cnt >= 3'h4
         |=> reg_rdata[UNLOCK_BIT] == $past(pll_unlock);
   endproperty
   a_unlock_read: assert property (p_unlock_read)
      else $error("unlock status bit differs from pin");
   property p_rdata_hold;
      !(ce && reg_rd) |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without a read");
   property p_unmapped;
      ce && reg_rd && (reg_addr < ADDR_DEV_CTRL || reg_addr > ADDR_FUNC2) |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_ce_hold;
      !ce |=> $stable(static_ratio) && $stable(normal_operation) && $stable(clk_out);
   endproperty
   a_ce_hold: assert property (p_ce_hold)
      else $error("state moved while clock enable low");
   property p_skip_src;
      $changed(skip_mode_enable) |-> $past(ce && reg_wr && reg_addr == ADDR_FUNC1, 2);
   endproperty
   a_skip_src: assert property (p_skip_src)
      else $error("skip enable changed without its write");
   property p_norm_src;
      $rose(normal_operation)
         |-> $past(ce && reg_wr && (reg_addr == ADDR_CFG1 || reg_addr == ADDR_GLOBAL), 2);
   endproperty
   a_norm_src: assert property (p_norm_src)
      else $error("normal operation rose without enable write");
endmodule
bind scb_top scb_assertions u_chk (.mclk, .sys_rst, .ce, .reg_addr, .reg_wr, .reg_rd,
   .reg_rdata, .pll_unlock, .dpll_ratio, .static_ratio, .frac_ratio,
   .fractional_source_select, .skip_mode_enable, .normal_operation, .clk_out);
`default_nettype wire

// ==== dv/scb_host.sv ====
/* Host model on the register strobe port: byte write and read tasks.
   Assumes requests launched at the falling edge of mclk. */
`timescale 1ns/100ps
`default_nettype none
module scb_host
   import scb_pkg::*;
(
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   // ****************************************
   // access tasks
   // ****************************************
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   function automatic logic [7:0] msk(input logic [7:0] a);
      case (a)
         ADDR_DEV_CTRL: return MASK_DEV_CTRL;
         ADDR_CFG1: return MASK_CFG1;
         ADDR_CFG2: return MASK_CFG2;
         ADDR_GLOBAL: return MASK_GLOBAL;
         ADDR_FUNC1: return MASK_FUNC1;
         ADDR_FUNC2: return MASK_FUNC2;
         default: return 8'hFF;
      endcase
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d & msk(a); // reserved bits kept at zero
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
/* Self-checking bench of the register bank.
   Assumes scb_top, the host model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module tb;
   import scb_pkg::*;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   logic timing_reference_clock = 1'b0;
   logic ref_run = 1'b0;
   logic freq_ref_clock = 1'b0;
   logic synth_clock = 1'b0;
   logic pll_unlock = 1'b0;
   logic [31:0] dpll_ratio = 32'hA5C3_0F96;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_wr, reg_rd;
   logic [31:0] static_ratio, hybrid_ratio, frac_ratio;
   logic fractional_source_select, skip_mode_enable, normal_operation;
   logic aux_out, aux_out_oe, clk_out, clk_out_oe, ref_div_clk;
   int miscompares = 0;
   int checks_done = 0;
   scb_top uut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .timing_reference_clock(timing_reference_clock), .freq_ref_clock(freq_ref_clock),
      .synth_clock(synth_clock), .pll_unlock(pll_unlock), .dpll_ratio(dpll_ratio),
      .static_ratio(static_ratio), .hybrid_ratio(hybrid_ratio), .frac_ratio(frac_ratio),
      .fractional_source_select(fractional_source_select),
      .skip_mode_enable(skip_mode_enable), .normal_operation(normal_operation),
      .aux_out(aux_out), .aux_out_oe(aux_out_oe), .clk_out(clk_out),
      .clk_out_oe(clk_out_oe), .ref_div_clk(ref_div_clk));
   scb_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   always #50 mclk = ~mclk;
   always #400 if (ref_run) timing_reference_clock = ~timing_reference_clock;
   // ****************************************
   // helpers and sequence
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      miscompares++;
      close_out;
   end
   initial begin
      logic [7:0] d;
      logic [31:0] rat [4];
      logic p;
      int ts, th, n;
      cyc(20);
      sys_rst = 1'b0;
      for (int a = 2; a < 24; a++) begin
         host.rd(8'(a), d);
         chk("reset_value", 8'h00, d);
      end
      host.rd(8'h20, d);
      chk("unmapped", 8'h00, d);
      for (int i = 0; i < 4; i++) begin
         rat[i] = 32'h1234_5678 + 32'(i) * 32'h1111_1111;
         for (int k = 0; k < 4; k++) begin
            host.wr(ADDR_RATIO_BASE + 8'(4 * i + k), rat[i][31 - 8 * k -: 8]);
         end
      end
      host.rd(8'h0B, d);
      chk("ratio_byte", rat[1][23:16], d);
      for (int s = 0; s < 4; s++) begin
         host.wr(ADDR_CFG1, 8'(s << 3) | 8'h01);
         host.wr(ADDR_CFG2, 8'(s << 1));
         cyc(3);
         chk("static_ratio", rat[s], static_ratio);
         chk("hybrid_ratio", rat[s], hybrid_ratio);
         chk("frac_static", rat[s], frac_ratio);
         chk("norm_first_only", 1'b0, normal_operation);
      end
      host.wr(ADDR_GLOBAL, 8'h01);
      cyc(3);
      chk("norm_both", 1'b1, normal_operation);
      host.wr(ADDR_CFG2, 8'h07);
      cyc(3);
      chk("frac_dpll", dpll_ratio, frac_ratio);
      chk("frac_bit", 1'b1, fractional_source_select);
      host.wr(ADDR_GLOBAL, 8'h09);
      host.wr(ADDR_CFG1, 8'h11);
      host.wr(ADDR_CFG2, 8'h02);
      cyc(3);
      chk("frozen", rat[3], static_ratio);
      host.rd(ADDR_CFG1, d);
      chk("staged", 8'h11, d);
      host.wr(ADDR_GLOBAL, 8'h01);
      ts = -1;
      th = -1;
      for (int i = 0; i < 6; i++) begin
         if (ts < 0 && static_ratio === rat[2]) ts = i;
         if (th < 0 && hybrid_ratio === rat[1]) th = i;
         @(negedge mclk);
      end
      chk("thaw_seen", 1'b1, ts >= 0);
      chk("thaw_same", ts, th);
      host.wr(ADDR_FUNC1, 8'h40);
      for (int s = 0; s < 3; s++) for (int v = 0; v < 2; v++) begin
         host.wr(ADDR_CFG1, 8'h11 | 8'(s << 1));
         timing_reference_clock = ((s == 0) == v[0]);
         freq_ref_clock = ((s == 1) == v[0]); // slow, gap-free source
         synth_clock = ((s == 2) == v[0]);
         cyc(5);
         chk("aux_source", v[0], aux_out);
         chk("aux_src_oe", 1'b1, aux_out_oe);
      end
      for (int c = 0; c < 2; c++) for (int u = 0; u < 2; u++) begin
         host.wr(ADDR_FUNC1, 8'(c << 6));
         host.wr(ADDR_CFG1, 8'h17);
         pll_unlock = u[0];
         cyc(5);
         chk("lock_out", c ? 1'b0 : u[0], aux_out);
         chk("lock_oe", c ? u[0] : 1'b1, aux_out_oe);
      end
      synth_clock = 1'b1;
      host.wr(ADDR_FUNC2, 8'h00);
      cyc(5);
      chk("unlock_gate", 1'b0, clk_out);
      host.rd(ADDR_DEV_CTRL, d);
      chk("unlock_bit", 1'b1, d[UNLOCK_BIT]);
      host.wr(ADDR_FUNC2, 8'h10);
      cyc(5);
      chk("unlock_pass", 1'b1, clk_out);
      pll_unlock = 1'b0;
      ref_run = 1'b1;
      for (int c = 0; c < 3; c++) begin
         host.wr(ADDR_FUNC1, 8'(c << 3) | 8'(c << 7));
         cyc(10);
         chk("skip", c == 1, skip_mode_enable);
         n = 0;
         p = ref_div_clk;
         for (int i = 0; i < 128; i++) begin
            @(negedge mclk);
            if (ref_div_clk === 1'b1 && p === 1'b0) n++;
            p = ref_div_clk;
         end
         chk("div_rises", 1'b1, n >= (4 << c) - 1 && n <= (4 << c) + 1);
      end
      host.wr(ADDR_DEV_CTRL, 8'h03);
      cyc(3);
      chk("clk_oe", 1'b0, clk_out_oe);
      chk("aux_oe", 1'b0, aux_out_oe);
      ref_run = 1'b0;
      ce = 1'b0;
      host.wr(ADDR_CFG1, 8'h01);
      cyc(3);
      chk("ce_hold", rat[2], static_ratio);
      ce = 1'b1;
      sys_rst = 1'b1;
      cyc(3);
      sys_rst = 1'b0;
      host.wr(ADDR_GLOBAL, 8'h01);
      cyc(3);
      chk("norm_second_only", 1'b0, normal_operation);
      host.wr(ADDR_CFG1, 8'h01);
      cyc(3);
      chk("norm_reverse", 1'b1, normal_operation);
      close_out;
   end
endmodule
`default_nettype wire
